// >>> hw/sfic_ctrl.sv
// function and init word control of a frequency synthesizer
// assumes pump events and phase detector cycles are same-clock pulses
// Behaviour
// R1: select 10 loads the function word
// R2: counter reset bit holds both dividers reset
// R3: counters restart together on reset release
// R4: chip enable low powers down at once
// R5: request with async select powers down immediately
// R6: request with sync select waits pump event
// R7: power-down loads counters, tristates pump, resets detector
// R8: serial loading keeps working during power-down
// R9: three-bit field selects test output source
// R10: fastlock only while enable bit set
// R11: mode bit picks software or timer exit
// R12: host boost bit enters and leaves fastlock
// R13: timer mode clears boost after chosen timeout
// R14: setting one static, setting two in fastlock
// R15: timeout counter runs only in timer mode
// R16: host keeps prescaler output within its limit
// R17: tristate bit floats the pump output
// R18: select 11 loads word and fires reset
// R19: init pulse also triggers requested power-down
// R20: first divider load after init refires pulse
// R21: host loads init, function, reference, divider
// R22: msb-first shift, strobe transfers chosen word
// R23: fastlock disabled means setting one always

`timescale 1ns/1ps

module sfic_ctrl #(
	parameter logic [7:0] TIMEOUT_STEP = sfic_pkg::SFIC_TIMEOUT_STEP
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n, // synchronous, active low
	input wire logic i_ser_clk, // serial clock pin
	input wire logic i_ser_data, // serial data pin
	input wire logic i_load_strobe, // load strobe pin
	input wire logic i_chip_enable, // chip enable pin
	input wire logic i_pump_event, // charge pump event pulse
	input wire logic i_pd_cycle, // phase detector cycle pulse
	output logic [sfic_pkg::SFIC_WORD_W-1:0] o_load_word,
	output logic o_ref_load, // reference word strobe
	output logic o_div_load, // divider word strobe
	output logic o_power_down,
	output logic o_counter_load, // hold counters at load state
	output logic o_init_reset_pulse,
	output logic o_pump_tristate, // charge_pump_output floats
	output logic [2:0] o_pump_current,
	output logic o_fastlock_active,
	output logic o_boost_request,
	output logic o_lock_det_rst,
	output logic o_ref_buf_en,
	output logic [2:0] o_out_mux_sel, // test_output_pin source
	output logic [1:0] o_prescaler_sel,
	output logic o_pd_polarity
);

	// ***************************************************************
	// declarations
	// ***************************************************************
	sfic_pkg::sfic_ctl_state_s st_r; // registered state
	sfic_pkg::sfic_ctl_state_s st_nxt; // next state
	logic [sfic_pkg::SFIC_WORD_W-1:0] ld_word; // captured word
	logic ld_valid; // one-cycle word pulse
	logic [1:0] ld_sel; // destination of the word
	sfic_pkg::sfic_fn_word_s ld_fn; // word seen as function word
	logic pd_async; // programmed asynchronous power-down
	logic pwr_down; // any power-down
	logic timer_run; // timeout counter may count
	logic [7:0] timer_lim; // last count before timeout

	// ***************************************************************
	// serial front end
	// ***************************************************************
	sfic_serial_load u_serial (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_ser_clk(i_ser_clk),
		.i_ser_data(i_ser_data),
		.i_load_strobe(i_load_strobe),
		.o_word(ld_word),
		.o_word_valid(ld_valid)
	);

	assign ld_sel = ld_word[1:0];
	assign ld_fn = sfic_pkg::sfic_fn_word_s'(ld_word);

	// ***************************************************************
	// derived power and timer terms
	// ***************************************************************
	// sync select low means act without waiting [R5]
	assign pd_async = st_r.fn.power_down_request &&
		!st_r.fn.power_down_sync_select;
	// pin low overrides both programmed bits [R4]
	assign pwr_down = !st_r.ce_s2 || pd_async || st_r.pd_sync;
	// timer counts only in timer-exit mode with fastlock on [R15] [R10]
	assign timer_run = st_r.fn.fastlock_enable && st_r.fn.fastlock_mode &&
		st_r.boost && !pwr_down && !st_r.rst_pulse; // [R11]
	// timeout grows in steps with the select field [R13]
	assign timer_lim = 8'(({4'h0, st_r.fn.fastlock_timeout_select} +
		8'h01) * TIMEOUT_STEP - 8'h01);

	// ***************************************************************
	// next state
	// ***************************************************************
	// order matters: timer clear first, word loads after, so a host
	// write landing on the timeout cycle is not lost
	always_comb begin
		st_nxt = st_r;
		st_nxt.ce_s1 = i_chip_enable;
		st_nxt.ce_s2 = st_r.ce_s1;
		st_nxt.rst_pulse = 1'b0;
		// synchronous power-down waits for a pump event [R6]
		if (!st_r.fn.power_down_request) begin
			st_nxt.pd_sync = 1'b0;
		end else if (st_r.fn.power_down_sync_select && i_pump_event) begin
			st_nxt.pd_sync = 1'b1;
		end
		// timeout counter, reloaded on power-down or pulse [R7] [R18]
		if (!timer_run) begin
			st_nxt.timer = '0;
		end else if (i_pd_cycle) begin
			if (st_r.timer == timer_lim) begin
				// timeout: drop back to setting one [R13]
				st_nxt.timer = '0;
				st_nxt.boost = 1'b0;
			end else begin
				st_nxt.timer = st_r.timer + 8'h01;
			end
		end
		if (ld_valid) begin
			case (ld_sel)
				sfic_pkg::SFIC_SEL_FUNC: begin
					st_nxt.fn = ld_fn; // [R1]
				end
				sfic_pkg::SFIC_SEL_INIT: begin
					// same fields plus an internal pulse [R18]
					st_nxt.fn = ld_fn;
					st_nxt.rst_pulse = 1'b1;
					st_nxt.init_armed = 1'b1;
					// pulse also takes the power-down [R19]
					if (st_r.ce_s2 && ld_fn.power_down_request &&
						!ld_fn.power_down_sync_select) begin
						st_nxt.pd_sync = 1'b1;
					end
				end
				sfic_pkg::SFIC_SEL_DIV: begin
					// host sets or clears boost [R12]
					st_nxt.boost = ld_word[sfic_pkg::SFIC_BOOST_BIT];
					// only the first load after init fires [R20]
					if (st_r.init_armed) begin
						st_nxt.rst_pulse = 1'b1;
						st_nxt.init_armed = 1'b0;
					end
				end
				default: begin
					// reference word leaves through o_ref_load
				end
			endcase
		end
	end

	// state register, synchronous reset
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			st_r <= sfic_pkg::SFIC_CTL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign o_load_word = ld_word;
	assign o_ref_load = ld_valid && ld_sel == sfic_pkg::SFIC_SEL_REF;
	assign o_div_load = ld_valid && ld_sel == sfic_pkg::SFIC_SEL_DIV;
	assign o_power_down = pwr_down;
	// one line for both dividers, so they leave reset on one edge
	assign o_counter_load = pwr_down || st_r.fn.counter_reset_bit ||
		st_r.rst_pulse; // [R2] [R3] [R7] [R18]
	// pump floats on its bit, power-down or any reset [R17] [R7]
	assign o_pump_tristate = o_counter_load || st_r.fn.pump_tristate;
	assign o_init_reset_pulse = st_r.rst_pulse;
	assign o_lock_det_rst = pwr_down; // [R7]
	assign o_ref_buf_en = !pwr_down; // [R7]
	// boost counts only while fastlock enabled [R10] [R23]
	assign o_fastlock_active = st_r.fn.fastlock_enable && st_r.boost;
	assign o_boost_request = st_r.boost;
	// setting two during fastlock, setting one otherwise [R14]
	assign o_pump_current = o_fastlock_active ?
		st_r.fn.pump_current_setting_two :
		st_r.fn.pump_current_setting_one;
	assign o_out_mux_sel = st_r.fn.out_mux_sel; // [R9]
	// choice of a legal value is the host's concern [R16]
	assign o_prescaler_sel = st_r.fn.prescaler_sel;
	assign o_pd_polarity = st_r.fn.pd_polarity;

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_rst_n);

	a_func_word_load: assert property ( // [R1]
		ld_valid && ld_sel == sfic_pkg::SFIC_SEL_FUNC |=>
		o_out_mux_sel == $past(ld_fn.out_mux_sel) &&
		o_prescaler_sel == $past(ld_fn.prescaler_sel))
		else $error("function word not applied");

	a_counter_hold: assert property ( // [R2]
		st_r.fn.counter_reset_bit |-> o_counter_load && o_pump_tristate)
		else $error("counter reset bit did not hold counters");

	a_pin_power_down: assert property ( // [R4]
		!i_chip_enable ##1 !i_chip_enable |=> o_power_down)
		else $error("chip enable low did not power down");

	a_async_pd_now: assert property ( // [R5]
		ld_valid && ld_sel == sfic_pkg::SFIC_SEL_FUNC &&
		ld_fn.power_down_request && !ld_fn.power_down_sync_select |=>
		o_power_down)
		else $error("asynchronous power-down late");

	a_sync_pd_wait: assert property ( // [R6]
		st_r.fn.power_down_request && st_r.fn.power_down_sync_select &&
		!st_r.pd_sync && !i_pump_event && !ld_valid |=> !st_r.pd_sync)
		else $error("synchronous power-down without pump event");

	a_pd_effects: assert property ( // [R7]
		o_power_down |-> o_counter_load && o_pump_tristate &&
		o_lock_det_rst && !o_ref_buf_en && st_nxt.timer == '0)
		else $error("power-down side effects missing");

	a_load_in_pd: assert property ( // [R8]
		o_power_down && ld_valid && ld_sel == sfic_pkg::SFIC_SEL_FUNC |=>
		st_r.fn == $past(ld_fn))
		else $error("word lost during power-down");

	a_boost_entry: assert property ( // [R12]
		ld_valid && ld_sel == sfic_pkg::SFIC_SEL_DIV |=>
		o_boost_request == $past(ld_word[sfic_pkg::SFIC_BOOST_BIT]))
		else $error("boost bit not taken");

	a_timeout_clear: assert property ( // [R13]
		timer_run && i_pd_cycle && st_r.timer == timer_lim && !ld_valid |=>
		!o_boost_request &&
		o_pump_current == st_r.fn.pump_current_setting_one)
		else $error("timeout did not clear boost");

	a_timer_idle: assert property ( // [R15]
		!st_r.fn.fastlock_mode |=> st_r.timer == '0)
		else $error("timer ran outside timer mode");

	a_init_pulse: assert property ( // [R18]
		ld_valid && ld_sel == sfic_pkg::SFIC_SEL_INIT |=>
		o_init_reset_pulse && o_pump_tristate ##1 !o_init_reset_pulse)
		else $error("init word pulse missing");

	a_first_div_pulse: assert property ( // [R20]
		ld_valid && ld_sel == sfic_pkg::SFIC_SEL_DIV |=>
		o_init_reset_pulse == $past(st_r.init_armed))
		else $error("divider pulse fired wrongly");

	a_static_current: assert property ( // [R23]
		!st_r.fn.fastlock_enable |->
		o_pump_current == st_r.fn.pump_current_setting_one)
		else $error("setting two used with fastlock off");

	// look at the latched flag: the async term alone would hide a
	// missing latch while the stored request is still set
	a_init_sync_pd: assert property ( // [R19]
		ld_valid && ld_sel == sfic_pkg::SFIC_SEL_INIT && st_r.ce_s2 &&
		ld_fn.power_down_request && !ld_fn.power_down_sync_select |=>
		st_r.pd_sync && o_power_down)
		else $error("init word did not take power-down");

	a_boost_current: assert property ( // [R14]
		o_fastlock_active |->
		o_pump_current == st_r.fn.pump_current_setting_two)
		else $error("setting two not used in fastlock");

	a_tristate_bit: assert property ( // [R17]
		st_r.fn.pump_tristate |-> o_pump_tristate)
		else $error("tristate bit did not float pump");

	a_load_strobe_once: assert property ( // [R22]
		o_ref_load || o_div_load |=> !o_ref_load && !o_div_load)
		else $error("word strobe longer than one cycle");

	// software exit: only a host write may end the boost
	a_mode_one_hold: assert property ( // [R11]
		o_fastlock_active && !st_r.fn.fastlock_mode && !ld_valid |=>
		o_boost_request)
		else $error("software-exit fastlock ended by itself");

	c_timeout_exit: cover property (
		timer_run && i_pd_cycle && st_r.timer == timer_lim);
	c_sync_pd_entry: cover property ($rose(st_r.pd_sync));
	c_init_then_div: cover property (
		o_init_reset_pulse ##[1:1000] o_div_load ##1 o_init_reset_pulse);
	c_boost_entry: cover property ($rose(o_fastlock_active));
	c_pin_pd_entry: cover property ($fell(st_r.ce_s2));

endmodule

// >>> hw/sfic_pkg.sv
// shared constants and packed types of the synthesizer control block
// assumes a single 50 MHz system clock and a 24-bit serial load word

package sfic_pkg;

	// ***************************************************************
	// word layout
	// ***************************************************************
	localparam int SFIC_WORD_W = 24; // serial word width
	localparam int SFIC_BOOST_BIT = 21; // boost request in divider word
	localparam int SFIC_TIMER_W = 8; // fastlock timer width

	// two lowest bits choose the destination word
	localparam logic [1:0] SFIC_SEL_REF = 2'h0;
	localparam logic [1:0] SFIC_SEL_DIV = 2'h1;
	localparam logic [1:0] SFIC_SEL_FUNC = 2'h2;
	localparam logic [1:0] SFIC_SEL_INIT = 2'h3;

	// ***************************************************************
	// timing
	// ***************************************************************
	localparam int SFIC_REF_CLK_MHZ = 50; // system clock rate
	// phase detector cycles per timeout step
	localparam logic [7:0] SFIC_TIMEOUT_STEP = 8'h04;

	// ***************************************************************
	// types
	// ***************************************************************
	// function and init word, msb first, bit 0 last
	typedef struct packed {
		logic [1:0] prescaler_sel; // bits 23:22
		logic power_down_sync_select; // bit 21
		logic [2:0] pump_current_setting_two; // bits 20:18
		logic [2:0] pump_current_setting_one; // bits 17:15
		logic [3:0] fastlock_timeout_select; // bits 14:11
		logic fastlock_mode; // bit 10
		logic fastlock_enable; // bit 9
		logic pump_tristate; // bit 8
		logic pd_polarity; // bit 7
		logic [2:0] out_mux_sel; // bits 6:4
		logic power_down_request; // bit 3
		logic counter_reset_bit; // bit 2
		logic [1:0] word_select; // bits 1:0
	} sfic_fn_word_s;

	// serial front end state
	typedef struct packed {
		logic clk_s1; // serial clock sync, stage one
		logic clk_s2; // serial clock sync, stage two
		logic clk_d; // delayed stage two for edge find
		logic dat_s1;
		logic dat_s2;
		logic strobe_s1;
		logic strobe_s2;
		logic strobe_d;
		logic [SFIC_WORD_W-1:0] shift; // input shift register
		logic [SFIC_WORD_W-1:0] word; // word captured on strobe
		logic valid; // one-cycle word pulse
	} sfic_ser_state_s;

	// control state
	typedef struct packed {
		logic ce_s1; // chip enable sync, stage one
		logic ce_s2;
		sfic_fn_word_s fn; // stored function word
		logic boost; // stored boost request
		logic [SFIC_TIMER_W-1:0] timer; // fastlock timeout counter
		logic pd_sync; // synchronous power-down taken
		logic init_armed; // next divider load fires pulse
		logic rst_pulse; // internal reset pulse
	} sfic_ctl_state_s;

	localparam sfic_ser_state_s SFIC_SER_RST = '0;
	localparam sfic_ctl_state_s SFIC_CTL_RST = '0;

endpackage

// >>> hw/sfic_serial_load.sv
// serial load port: shift register and strobe transfer
// assumes serial pins are asynchronous to i_ref_clk and much slower

`timescale 1ns/1ps

module sfic_serial_load (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_ser_clk, // serial clock pin
	input wire logic i_ser_data, // serial data pin
	input wire logic i_load_strobe, // load strobe pin
	output logic [sfic_pkg::SFIC_WORD_W-1:0] o_word,
	output logic o_word_valid
);

	sfic_pkg::sfic_ser_state_s st_r; // registered state
	sfic_pkg::sfic_ser_state_s st_nxt; // next state

	// ***************************************************************
	// next state
	// ***************************************************************
	// never gated by power-down so words still load [R8]
	always_comb begin
		st_nxt = st_r;
		st_nxt.clk_s1 = i_ser_clk;
		st_nxt.clk_s2 = st_r.clk_s1;
		st_nxt.clk_d = st_r.clk_s2;
		st_nxt.dat_s1 = i_ser_data;
		st_nxt.dat_s2 = st_r.dat_s1;
		st_nxt.strobe_s1 = i_load_strobe;
		st_nxt.strobe_s2 = st_r.strobe_s1;
		st_nxt.strobe_d = st_r.strobe_s2;
		st_nxt.valid = 1'b0;
		// rising serial clock: shift in, msb arrives first [R22]
		if (st_r.clk_s2 && !st_r.clk_d) begin
			st_nxt.shift = {st_r.shift[sfic_pkg::SFIC_WORD_W-2:0],
				st_r.dat_s2};
		end
		// rising strobe: hand the word over [R22]
		if (st_r.strobe_s2 && !st_r.strobe_d) begin
			st_nxt.word = st_r.shift;
			st_nxt.valid = 1'b1;
		end
	end

	// state register, synchronous reset
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			st_r <= sfic_pkg::SFIC_SER_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_word = st_r.word;
	assign o_word_valid = st_r.valid;

	// ***************************************************************
	// checks
	// ***************************************************************
	a_shift_msb_first: assert property (@(posedge i_ref_clk) // [R22]
		disable iff (!i_rst_n)
		(st_r.clk_s2 && !st_r.clk_d) |=>
		st_r.shift[0] == $past(st_r.dat_s2) &&
		st_r.shift[sfic_pkg::SFIC_WORD_W-1:1] ==
		$past(st_r.shift[sfic_pkg::SFIC_WORD_W-2:0]))
		else $error("shift register did not take data");

	a_strobe_word_xfer: assert property (@(posedge i_ref_clk) // [R22]
		disable iff (!i_rst_n)
		(st_r.strobe_s2 && !st_r.strobe_d) |=>
		o_word_valid && o_word == $past(st_r.shift) ##1 !o_word_valid)
		else $error("strobe did not transfer word once");

endmodule

// >>> bench/sfic_host_model.sv
// host side of the serial load port, shifting 24-bit words msb first
// assumes the bench calls send_word and shares the reference clock
`timescale 1ns/1ps

module sfic_host_model (
	input wire logic i_ref_clk,
	output logic o_ser_clk, // link clock, low between frames
	output logic o_ser_data, // serial data, no pull on the line
	output logic o_load_strobe // load strobe
);
	// ***************************************************************
	// idle levels
	// ***************************************************************
	initial begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		o_load_strobe = 1'b0;
	end

	// four ref clocks a level: 80 ns halves, 160 ns link period
	task automatic hold4();
		repeat (4) @(posedge i_ref_clk);
	endtask

	// ***************************************************************
	// one frame
	// ***************************************************************
	// data changes while the clock is low, so it is settled at the rise
	task automatic send_word(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			o_ser_data <= w[i];
			hold4();
			o_ser_clk <= 1'b1;
			hold4();
			o_ser_clk <= 1'b0;
		end
		// released line shows the inverse, not the last bit
		o_ser_data <= ~w[0];
		hold4();
		o_load_strobe <= 1'b1;
		hold4();
		o_load_strobe <= 1'b0;
		hold4();
	endtask
endmodule

// >>> bench/sfic_ctrl_tb.sv
// self-checking bench of the function and init word control
// assumes the host model drives the serial pins; timeout step set to 1
`timescale 1ns/1ps

module sfic_ctrl_tb;
	// ***************************************************************
	// stimulus and observed signals
	// ***************************************************************
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic ce = 1'b1; // chip enable pin
	logic pump_ev = 1'b0; // charge pump event
	logic pd_cyc = 1'b0; // phase detector tick
	logic ser_clk, ser_data, strobe;
	logic [23:0] load_word;
	logic ref_load, div_load, pd, cl, pulse, tri_st, fl_act, boost;
	logic ldr, rbe, pol;
	logic [2:0] cur, mux;
	logic [1:0] presc;
	int fails = 0;
	int n_compared = 0;
	int n_pulse = 0; // init reset pulses seen
	int n_ref = 0;
	int n_div = 0;
	int cycles = 0;

	// ordinary cases: word, then pd, counter load, tristate, current
	typedef struct packed {
		logic [23:0] w;
		logic pd;
		logic cl;
		logic ts;
		logic [2:0] cur;
	} sfic_row_s;
	sfic_row_s rows [4] = '{
		'{24'h9981d6, 1'b0, 1'b1, 1'b1, 3'h3}, // counter reset, floated
		'{24'h9981d2, 1'b0, 1'b0, 1'b1, 3'h3}, // tristate bit only
		'{24'h9980da, 1'b1, 1'b1, 1'b1, 3'h3}, // async power-down
		'{24'h9980d2, 1'b0, 1'b0, 1'b0, 3'h3}}; // normal run

	always #10 i_ref_clk = ~i_ref_clk;

	sfic_host_model u_host (.i_ref_clk(i_ref_clk), .o_ser_clk(ser_clk),
		.o_ser_data(ser_data), .o_load_strobe(strobe));

	// short timeout step keeps the timer scenario brief
	sfic_ctrl #(.TIMEOUT_STEP(8'h01)) u_dut (.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n), .i_ser_clk(ser_clk), .i_ser_data(ser_data),
		.i_load_strobe(strobe), .i_chip_enable(ce), .i_pump_event(pump_ev),
		.i_pd_cycle(pd_cyc), .o_load_word(load_word), .o_ref_load(ref_load),
		.o_div_load(div_load), .o_power_down(pd), .o_counter_load(cl),
		.o_init_reset_pulse(pulse), .o_pump_tristate(tri_st),
		.o_pump_current(cur), .o_fastlock_active(fl_act),
		.o_boost_request(boost), .o_lock_det_rst(ldr), .o_ref_buf_en(rbe),
		.o_out_mux_sel(mux), .o_prescaler_sel(presc), .o_pd_polarity(pol));

	// ***************************************************************
	// helpers
	// ***************************************************************
	task automatic check(input logic [23:0] seen, input logic [23:0] exp,
		input string what);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: %s seen %h expected %h", $time, what,
				seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one frame, then time for the fields to land
	task automatic load(input logic [23:0] w);
		u_host.send_word(w);
		repeat (6) @(posedge i_ref_clk);
	endtask

	// one phase detector tick, one cycle wide
	task automatic tick();
		@(posedge i_ref_clk) pd_cyc <= 1'b1;
		@(posedge i_ref_clk) pd_cyc <= 1'b0;
	endtask

	// pulse counters and the hang guard
	always @(posedge i_ref_clk) begin
		cycles++;
		if (pulse === 1'b1) n_pulse++;
		if (ref_load === 1'b1) n_ref++;
		if (div_load === 1'b1) n_div++;
		if (cycles == 60000) begin
			fails++;
			stop_test();
		end
	end

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		repeat (12) @(posedge i_ref_clk);
		check(pd, 1'b1, "pd in reset");
		check(cl, 1'b1, "counter load in reset");
		@(posedge i_ref_clk) i_rst_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		// power-up order: init, function, reference, divider
		load(24'h9980d3);
		check(24'(n_pulse), 24'h1, "init pulse");
		load(24'h9980d2);
		load(24'h000000);
		check(24'(n_ref), 24'h1, "reference strobe");
		load(24'h000001);
		check(24'(n_pulse), 24'h2, "first divider pulse");
		load(24'h000001);
		check(24'(n_pulse), 24'h2, "later divider pulse");
		check(24'(n_div), 24'h2, "divider strobes");
		// table of ordinary cases
		foreach (rows[i]) begin
			load(rows[i].w);
			check(load_word, rows[i].w, "word");
			check(pd, rows[i].pd, "power-down");
			check(cl, rows[i].cl, "counter load");
			check(tri_st, rows[i].ts, "tristate");
			check(ldr, rows[i].pd, "lock reset");
			check(rbe, !rows[i].pd, "ref buffer");
			if (!rows[i].pd) check(cur, rows[i].cur, "current");
		end
		check(presc, 2'h2, "prescaler");
		check(pol, 1'b1, "polarity");
		// every test output source
		for (int m = 0; m < 8; m++) begin
			load(24'h998002 | 24'(m << 4));
			check(mux, m[2:0], "mux select");
		end
		// synchronous power-down waits for the pump event
		load(24'hb980da);
		repeat (20) @(posedge i_ref_clk);
		check(pd, 1'b0, "pd before event");
		@(posedge i_ref_clk) pump_ev <= 1'b1;
		@(posedge i_ref_clk) pump_ev <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		check(pd, 1'b1, "sync pd");
		load(24'h9980d2);
		check(pd, 1'b0, "pd cleared");
		// chip enable low; loading still works meanwhile
		@(posedge i_ref_clk) ce <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		check(pd, 1'b1, "pin pd");
		check(tri_st, 1'b1, "pin pd tristate");
		load(24'h998072);
		check(mux, 3'h7, "load in pd");
		@(posedge i_ref_clk) ce <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		check(pd, 1'b0, "pin pd ends");
		// init word with request and async select
		load(24'h9980db);
		check(pd, 1'b1, "init pd");
		// sync select now set: only the latched init power-down holds it
		load(24'hb980da);
		check(pd, 1'b1, "init pd held");
		load(24'h9980d2);
		// software-exit fastlock, setting two while boosted
		load(24'h9982d2);
		load(24'h200001);
		check(cur, 3'h6, "boost current");
		check(fl_act, 1'b1, "fastlock on");
		repeat (10) tick();
		check(cur, 3'h6, "no timer exit");
		load(24'h000001);
		check(cur, 3'h3, "boost off");
		// fastlock disabled ignores boost
		load(24'h9980d2);
		load(24'h200001);
		check(cur, 3'h3, "disabled current");
		check(fl_act, 1'b0, "fastlock off");
		load(24'h000001);
		// timer exit: select 2 gives three ticks at step 1
		load(24'h9996d2);
		load(24'h200001);
		repeat (2) tick();
		repeat (2) @(posedge i_ref_clk);
		check(boost, 1'b1, "boost before limit");
		tick();
		repeat (2) @(posedge i_ref_clk);
		check(boost, 1'b0, "boost timed out");
		check(cur, 3'h3, "back to setting one");
		// reset in mid-run: stored word cleared, pin sync restarts
		@(posedge i_ref_clk) i_rst_n <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
		check(pd, 1'b1, "pd in second reset");
		check(cl, 1'b1, "counter load in second reset");
		check(tri_st, 1'b1, "tristate in second reset");
		@(posedge i_ref_clk) i_rst_n <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		check(pd, 1'b0, "pd after second release");
		stop_test();
	end
endmodule
